/* port_pin_sharing_logic.sv */
// Top of the port and pin-sharing logic
//
// What this block does
// - Open-drain bits read input when latch is one
// - Open-drain pins only pull low, never drive high
// - Port five direction bit: zero input, one push-pull
// - Timer pin A: timer two clock, timer one toggle
// - Timer pin B: timer four clock, timer three toggle
// - Interrupt pins raise requests and wake system
// - Port two bits share serial clock and data
// - Analog zero to three feed comparators when selected
// - Port D bits share analog channels four to seven
// - Shared pins keep digital input paths readable
// - Port five directions clear to input on reset
// - Open-drain latches reset released, pins high-impedance
// - Pull-up enable one; wake enable zero disables
// - Smaller variant drops ports and upper channels
// - Ports zero and one have wake and pull-up
`timescale 1ns/1ps
`default_nettype none
module port_pin_sharing_logic
   import port_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0
)
(
   input  wire logic       CLK_I,
   input  wire logic       NRST_I,
   input  wire logic [3:0] ADDR_I,
   input  wire logic [3:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic      [3:0] RDATA_O,
   input  wire logic [3:0] PORT_C_I,
   output logic      [3:0] PORT_C_O,
   output logic      [3:0] PORT_C_OE_O,
   input  wire logic [3:0] PORT_D_I,
   output logic      [3:0] PORT_D_O,
   output logic      [3:0] PORT_D_OE_O,
   input  wire logic [3:0] PUSH_PULL_I,
   output logic      [3:0] PUSH_PULL_O,
   output logic      [3:0] PUSH_PULL_OE_O,
   input  wire logic [1:0] PIN_D_I,
   output logic      [1:0] PIN_D_O,
   output logic      [1:0] PIN_D_OE_O,
   input  wire logic [2:0] PORT_P2_I,
   input  wire logic [3:0] PORT_P0_I,
   input  wire logic [3:0] PORT_P1_I,
   input  wire logic       TIMER1_TOGGLE_I,
   input  wire logic       TIMER3_TOGGLE_I,
   input  wire logic       SERIAL_CK_OUT_I,
   input  wire logic       SERIAL_CK_DIR_I,
   output logic            TIMER2_CLK_O,
   output logic            TIMER4_CLK_O,
   output logic            EXT_IRQ_A_O,
   output logic            EXT_IRQ_B_O,
   output logic            WAKE_O,
   output logic            SERIAL_CK_IN_O,
   output logic            SERIAL_IN_O,
   output logic      [7:0] ANALOG_CH_EN_O,
   output logic            COMPARATOR_EN_O,
   output logic      [3:0] PULLUP_ON_O
);
   logic [3:0] mask_c;
   logic [3:0] mask_d;
   logic [3:0] port_c_latch_q;
   logic [3:0] port_c_latch_d;
   logic [3:0] port_d_latch_q;
   logic [3:0] port_d_latch_d;
   logic [3:0] push_pull_latch_q;
   logic [3:0] push_pull_latch_d;
   logic [3:0] port5_direction_reg_q;
   logic [3:0] port5_direction_reg_d;
   logic [3:0] pullup_enable_reg_q;
   logic [3:0] pullup_enable_reg_d;
   logic [3:0] keyon_wake_enable_reg_q;
   logic [3:0] keyon_wake_enable_reg_d;
   logic [3:0] func_sel_q;
   logic [3:0] func_sel_d;
   logic [1:0] pin_d_latch_q;
   logic [1:0] pin_d_latch_d;
   logic [3:0] rdata_q;
   logic [3:0] rdata_d;
   logic [3:0] c_oe_q;
   logic [3:0] c_oe_d;
   logic [3:0] d_oe_q;
   logic [3:0] d_oe_d;
   logic [3:0] pp_oe_q;
   logic [3:0] pp_oe_d;
   logic [3:0] pp_o_q;
   logic [3:0] pp_o_d;
   logic [1:0] pd_oe_q;
   logic [1:0] pd_oe_d;
   logic       t2_q;
   logic       t2_d;
   logic       t4_q;
   logic       t4_d;
   logic       irqa_q;
   logic       irqa_d;
   logic       irqb_q;
   logic       irqb_d;
   logic       wake_q;
   logic       wake_d;
   logic       sck_q;
   logic       sck_d;
   logic       sin_q;
   logic       sin_d;
   logic       cmp_q;
   logic       cmp_d;
   logic [7:0] ach_q;
   logic [7:0] ach_d;
   logic [3:0] pu_q;
   logic [3:0] pu_d;
   logic [3:0] c_s;
   logic [3:0] d_s;
   logic [3:0] pp_s;
   logic [3:0] p0_s;
   logic [3:0] p1_s;
   logic [1:0] pd_s;
   logic [2:0] p2_s;
   logic [7:0] key_low;
   logic [3:0] pair_low;

   sync_if sif ();

   // Every pin level is synchronised before use
   assign sif.raw = {PORT_C_I, PORT_D_I, PUSH_PULL_I, PIN_D_I, PORT_P2_I, PORT_P0_I, PORT_P1_I};
   assign {c_s, d_s, pp_s, pd_s, p2_s, p0_s, p1_s} = sif.synced;

   pin_sync u_sync
   (
      .CLK_I  (CLK_I),
      .NRST_I (NRST_I),
      .s      (sif.dst)
   );

   // Absent bits on the smaller part stay released and read zero
   assign mask_c = SMALL_VARIANT ? SMALL_MASK_C : FULL_MASK;
   assign mask_d = SMALL_VARIANT ? NO_MASK : FULL_MASK;

   always_comb
   begin
      port_c_latch_d          = port_c_latch_q;
      port_d_latch_d          = port_d_latch_q;
      push_pull_latch_d       = push_pull_latch_q;
      port5_direction_reg_d   = port5_direction_reg_q;
      pullup_enable_reg_d     = pullup_enable_reg_q;
      keyon_wake_enable_reg_d = keyon_wake_enable_reg_q;
      func_sel_d              = func_sel_q;
      pin_d_latch_d           = pin_d_latch_q;
      if (WR_I)
      begin
         if (ADDR_I == ADDR_PORT_C)
            port_c_latch_d = WDATA_I | ~mask_c;
         else if (ADDR_I == ADDR_PORT_D)
            port_d_latch_d = WDATA_I | ~mask_d;
         else if (ADDR_I == ADDR_PUSH_PULL)
            push_pull_latch_d = WDATA_I & mask_d;
         else if (ADDR_I == ADDR_DIRECTION)
            port5_direction_reg_d = WDATA_I & mask_d;
         else if (ADDR_I == ADDR_PULLUP)
            pullup_enable_reg_d = WDATA_I;
         else if (ADDR_I == ADDR_KEYON)
            keyon_wake_enable_reg_d = WDATA_I;
         else if (ADDR_I == ADDR_FUNC_SEL)
            func_sel_d = WDATA_I;
         else if (ADDR_I == ADDR_PIN_D)
            pin_d_latch_d = WDATA_I[1:0];
      end
   end

   // Port reads show pin levels, so a released pin shows the board level
   always_comb
   begin
      rdata_d = 4'h0;
      if (RD_I)
      begin
         if (ADDR_I == ADDR_PORT_C)
            rdata_d = c_s & mask_c;
         else if (ADDR_I == ADDR_PORT_D)
            rdata_d = d_s & mask_d;
         else if (ADDR_I == ADDR_PUSH_PULL)
            rdata_d = pp_s & mask_d;
         else if (ADDR_I == ADDR_DIRECTION)
            rdata_d = port5_direction_reg_q;
         else if (ADDR_I == ADDR_PULLUP)
            rdata_d = pullup_enable_reg_q;
         else if (ADDR_I == ADDR_KEYON)
            rdata_d = keyon_wake_enable_reg_q;
         else if (ADDR_I == ADDR_FUNC_SEL)
            rdata_d = func_sel_q;
         else if (ADDR_I == ADDR_PIN_D)
            rdata_d = {2'h0, pd_s};
         else if (ADDR_I == ADDR_PORT_P2)
            rdata_d = {1'b0, p2_s};
         else if (ADDR_I == ADDR_PORT_P0)
            rdata_d = p0_s;
         else if (ADDR_I == ADDR_PORT_P1)
            rdata_d = p1_s;
      end
   end

   // Pin drivers and function routing
   always_comb
   begin
      // Latch zero pulls low; a one only releases the pin
      c_oe_d  = ~port_c_latch_q & mask_c;
      d_oe_d  = ~port_d_latch_q & mask_d;
      pd_oe_d = ~pin_d_latch_q;
      if (func_sel_q[FSEL_TIMER_A] && TIMER1_TOGGLE_I)
         pd_oe_d[0] = 1'b0;
      else if (func_sel_q[FSEL_TIMER_A] && !TIMER1_TOGGLE_I)
         pd_oe_d[0] = 1'b1;
      if (func_sel_q[FSEL_TIMER_B] && TIMER3_TOGGLE_I)
         pd_oe_d[1] = 1'b0;
      else if (func_sel_q[FSEL_TIMER_B] && !TIMER3_TOGGLE_I)
         pd_oe_d[1] = 1'b1;
      pp_oe_d = port5_direction_reg_q & mask_d;
      pp_o_d  = push_pull_latch_q & mask_d;
      t2_d    = pd_s[0];
      t4_d    = pd_s[1];
      irqa_d  = c_s[0];
      irqb_d  = c_s[1];
      sck_d   = SERIAL_CK_DIR_I ? SERIAL_CK_OUT_I : p2_s[0];
      sin_d   = p2_s[2];
      cmp_d   = func_sel_q[FSEL_COMPARATOR];
      ach_d   = {mask_d, cmp_d ? 4'h0 : 4'hF};
      // One control bit per pin pair
      for (int i = 0; i < 4; i++)
      begin
         key_low[2*i]   = ~p0_s[i];
         key_low[2*i+1] = ~p1_s[i];
      end
      for (int k = 0; k < 4; k++)
      begin
         pair_low[k] = (key_low[2*k] | key_low[2*k+1]) & keyon_wake_enable_reg_q[k];
      end
      pu_d   = pullup_enable_reg_q;
      // Wake on low pin level; software restores latches after wake
      wake_d = (|pair_low) | ~c_s[0] | ~c_s[1];
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         port_c_latch_q          <= LATCH_RESET;
         port_d_latch_q          <= LATCH_RESET;
         push_pull_latch_q       <= DIR_RESET;
         port5_direction_reg_q   <= DIR_RESET;
         pullup_enable_reg_q     <= PULLUP_RESET;
         keyon_wake_enable_reg_q <= KEYON_RESET;
         func_sel_q              <= FUNC_RESET;
         pin_d_latch_q           <= PIN_D_RESET;
         rdata_q                 <= 4'h0;
         c_oe_q  <= 4'h0;
         d_oe_q  <= 4'h0;
         pd_oe_q <= 2'h0;
         pp_oe_q <= 4'h0;
         pp_o_q  <= 4'h0;
         t2_q    <= 1'b0;
         t4_q    <= 1'b0;
         irqa_q  <= 1'b0;
         irqb_q  <= 1'b0;
         wake_q  <= 1'b0;
         sck_q   <= 1'b0;
         sin_q   <= 1'b0;
         cmp_q   <= 1'b0;
         ach_q   <= 8'h00;
         pu_q    <= 4'h0;
      end
      else
      begin
         port_c_latch_q          <= port_c_latch_d;
         port_d_latch_q          <= port_d_latch_d;
         push_pull_latch_q       <= push_pull_latch_d;
         port5_direction_reg_q   <= port5_direction_reg_d;
         pullup_enable_reg_q     <= pullup_enable_reg_d;
         keyon_wake_enable_reg_q <= keyon_wake_enable_reg_d;
         func_sel_q              <= func_sel_d;
         pin_d_latch_q           <= pin_d_latch_d;
         rdata_q                 <= rdata_d;
         c_oe_q  <= c_oe_d;
         d_oe_q  <= d_oe_d;
         pd_oe_q <= pd_oe_d;
         pp_oe_q <= pp_oe_d;
         pp_o_q  <= pp_o_d;
         t2_q    <= t2_d;
         t4_q    <= t4_d;
         irqa_q  <= irqa_d;
         irqb_q  <= irqb_d;
         wake_q  <= wake_d;
         sck_q   <= sck_d;
         sin_q   <= sin_d;
         cmp_q   <= cmp_d;
         ach_q   <= ach_d;
         pu_q    <= pu_d;
      end
   end

   assign RDATA_O         = rdata_q;
   assign PORT_C_O        = 4'h0;
   assign PORT_C_OE_O     = c_oe_q;
   assign PORT_D_O        = 4'h0;
   assign PORT_D_OE_O     = d_oe_q;
   assign PIN_D_O         = 2'h0;
   assign PIN_D_OE_O      = pd_oe_q;
   assign PUSH_PULL_O     = pp_o_q;
   assign PUSH_PULL_OE_O  = pp_oe_q;
   assign TIMER2_CLK_O    = t2_q;
   assign TIMER4_CLK_O    = t4_q;
   assign EXT_IRQ_A_O     = irqa_q;
   assign EXT_IRQ_B_O     = irqb_q;
   assign WAKE_O          = wake_q;
   assign SERIAL_CK_IN_O  = sck_q;
   assign SERIAL_IN_O     = sin_q;
   assign ANALOG_CH_EN_O  = ach_q;
   assign COMPARATOR_EN_O = cmp_q;
   assign PULLUP_ON_O     = pu_q;
endmodule
`default_nettype wire

/* port_pkg.sv */
// Constants shared by the port and pin-sharing logic
package port_pkg;
   localparam logic [3:0] ADDR_PORT_C     = 4'h0;
   localparam logic [3:0] ADDR_PORT_D     = 4'h1;
   localparam logic [3:0] ADDR_PUSH_PULL  = 4'h2;
   localparam logic [3:0] ADDR_DIRECTION  = 4'h3;
   localparam logic [3:0] ADDR_PULLUP     = 4'h4;
   localparam logic [3:0] ADDR_KEYON      = 4'h5;
   localparam logic [3:0] ADDR_FUNC_SEL   = 4'h6;
   localparam logic [3:0] ADDR_PIN_D      = 4'h7;
   localparam logic [3:0] ADDR_PORT_P2    = 4'h8;
   localparam logic [3:0] ADDR_PORT_P0    = 4'h9;
   localparam logic [3:0] ADDR_PORT_P1    = 4'hA;
   localparam logic [3:0] LATCH_RESET     = 4'hF;
   localparam logic [3:0] DIR_RESET       = 4'h0;
   localparam logic [3:0] PULLUP_RESET    = 4'h0;
   localparam logic [3:0] KEYON_RESET     = 4'h0;
   localparam logic [3:0] FUNC_RESET      = 4'h0;
   localparam logic [1:0] PIN_D_RESET     = 2'h3;
   localparam int         FSEL_TIMER_A    = 0;
   localparam int         FSEL_TIMER_B    = 1;
   localparam int         FSEL_SERIAL_CK  = 2;
   localparam int         FSEL_COMPARATOR = 3;
   localparam logic [3:0] SMALL_MASK_C    = 4'h3;
   localparam logic [3:0] FULL_MASK       = 4'hF;
   localparam logic [3:0] NO_MASK         = 4'h0;
endpackage

/* sync_if.sv */
// Interface carrying raw and synchronised pin levels
`timescale 1ns/1ps
`default_nettype none
interface sync_if;
   logic [24:0] raw;
   logic [24:0] synced;
   modport src (output raw, input synced);
   modport dst (input raw, output synced);
endinterface
`default_nettype wire

/* pin_sync.sv */
// Two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
   input  wire logic CLK_I,
   input  wire logic NRST_I,
   sync_if.dst       s
);
   logic [24:0] meta_q;
   logic [24:0] meta_d;
   logic [24:0] sync_q;
   logic [24:0] sync_d;

   always_comb
   begin
      meta_d = s.raw;
      sync_d = meta_q;
   end

   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         // Pulled-up idle level, so no false wake right after reset
         meta_q <= 25'h1FFFFFF;
         sync_q <= 25'h1FFFFFF;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign s.synced = sync_q;
endmodule
`default_nettype wire

/* board_model.sv */
// Board model: pull-ups and outside drivers on the pins
`timescale 1ns/1ps
`default_nettype none
module board_model
(
   input  wire logic [3:0] c_oe_i,
   input  wire logic [3:0] d_oe_i,
   input  wire logic [1:0] pd_oe_i,
   input  wire logic [3:0] pp_i,
   input  wire logic [3:0] pp_oe_i,
   input  wire logic [3:0] c_ext_i,
   input  wire logic [3:0] d_ext_i,
   input  wire logic [1:0] pd_ext_i,
   input  wire logic [3:0] pp_ext_i,
   output logic      [3:0] c_o,
   output logic      [3:0] d_o,
   output logic      [1:0] pd_o,
   output logic      [3:0] pp_o
);
   // Wired-AND with pull-up on open-drain pins, so a released pin shows the outside level
   assign c_o = c_ext_i & ~c_oe_i;
   assign d_o = d_ext_i & ~d_oe_i;
   assign pd_o = pd_ext_i & ~pd_oe_i;
   assign pp_o = (pp_oe_i & pp_i) | (~pp_oe_i & pp_ext_i);
endmodule
`default_nettype wire

/* port_checker.sv */
// Assertions on the ports of the pin-sharing top
`timescale 1ns/1ps
`default_nettype none
module port_checker
   import port_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0
)
(
   input wire logic       CLK_I,
   input wire logic       NRST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [3:0] WDATA_I,
   input wire logic       WR_I,
   input wire logic       RD_I,
   input wire logic [3:0] RDATA_O,
   input wire logic [3:0] PORT_C_I,
   input wire logic [3:0] PORT_C_O,
   input wire logic [3:0] PORT_C_OE_O,
   input wire logic [3:0] PORT_D_O,
   input wire logic [3:0] PORT_D_OE_O,
   input wire logic [3:0] PUSH_PULL_OE_O,
   input wire logic [1:0] PIN_D_I,
   input wire logic [1:0] PIN_D_O,
   input wire logic [2:0] PORT_P2_I,
   input wire logic       TIMER2_CLK_O,
   input wire logic       TIMER4_CLK_O,
   input wire logic       EXT_IRQ_A_O,
   input wire logic       EXT_IRQ_B_O,
   input wire logic       SERIAL_IN_O,
   input wire logic       WAKE_O,
   input wire logic [7:0] ANALOG_CH_EN_O,
   input wire logic       COMPARATOR_EN_O,
   input wire logic [3:0] PULLUP_ON_O
);
   localparam logic [3:0] MC = SMALL_VARIANT ? SMALL_MASK_C : FULL_MASK;
   localparam logic [3:0] MP = SMALL_VARIANT ? NO_MASK : FULL_MASK;
   // Sync stages hold reset values, so wait three edges
   logic [1:0] up_q;
   logic [1:0] up_d;
   wire logic  live = up_q == 2'h3;
   always_comb up_d = live ? up_q : up_q + 2'h1;
   always_ff @(posedge CLK_I or negedge NRST_I)
   begin
      if (!NRST_I) up_q <= 2'h0;
      else up_q <= up_d;
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   od_low_only_a: assert property ((PORT_C_O | PORT_D_O) == 4'h0 && PIN_D_O == 2'h0)
      else $error("open drain drives high");
   latch_c_a: assert property (WR_I && ADDR_I == ADDR_PORT_C |-> ##2 PORT_C_OE_O == (~$past(WDATA_I, 2) & MC))
      else $error("port c enable wrong");
   latch_d_a: assert property (WR_I && ADDR_I == ADDR_PORT_D |-> ##2 PORT_D_OE_O == (~$past(WDATA_I, 2) & MP))
      else $error("port d enable wrong");
   dir_pp_a: assert property (WR_I && ADDR_I == ADDR_DIRECTION |-> ##2 PUSH_PULL_OE_O == ($past(WDATA_I, 2) & MP))
      else $error("direction wrong");
   timer_sync_a: assert property (live |-> {TIMER4_CLK_O, TIMER2_CLK_O} == $past(PIN_D_I, 3))
      else $error("timer clock wrong");
   irq_sync_a: assert property (live |-> {EXT_IRQ_B_O, EXT_IRQ_A_O} == $past(PORT_C_I[1:0], 3))
      else $error("irq level wrong");
   serial_sync_a: assert property (live |-> SERIAL_IN_O == $past(PORT_P2_I[2], 3))
      else $error("serial in wrong");
   analog_sel_a: assert property (live |-> ANALOG_CH_EN_O == {MP, {4{~COMPARATOR_EN_O}}})
      else $error("analog enables wrong");
   pullup_wr_a: assert property (WR_I && ADDR_I == ADDR_PULLUP |-> ##2 PULLUP_ON_O == $past(WDATA_I, 2))
      else $error("pull-up wrong");
   rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 4'h0)
      else $error("read data outside read");
   cover property (WR_I && ADDR_I == ADDR_FUNC_SEL && WDATA_I[3]);
   cover property (RD_I && ADDR_I == ADDR_PORT_C);
   cover property ($rose(WAKE_O));
endmodule
bind port_pin_sharing_logic port_checker #(.SMALL_VARIANT(SMALL_VARIANT)) chk_u (.CLK_I, .NRST_I, .ADDR_I,
   .WDATA_I, .WR_I, .RD_I, .RDATA_O, .PORT_C_I, .PORT_C_O, .PORT_C_OE_O, .PORT_D_O, .PORT_D_OE_O,
   .PUSH_PULL_OE_O, .PIN_D_I, .PIN_D_O, .PORT_P2_I, .TIMER2_CLK_O, .TIMER4_CLK_O, .EXT_IRQ_A_O,
   .EXT_IRQ_B_O, .SERIAL_IN_O, .WAKE_O, .ANALOG_CH_EN_O, .COMPARATOR_EN_O, .PULLUP_ON_O);
`default_nettype wire

/* testbench.sv */
// Register-level tests of the pin-sharing logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import port_pkg::*;
   logic CLK_I = 1'b0, NRST_I = 1'b0, WR_I = 1'b0, RD_I = 1'b0;
   logic [3:0] ADDR_I = 4'h0, WDATA_I = 4'h0, PORT_P0_I = 4'hF, PORT_P1_I = 4'hF;
   logic [2:0] PORT_P2_I = 3'h0;
   logic TIMER1_TOGGLE_I = 1'b0, TIMER3_TOGGLE_I = 1'b0, SERIAL_CK_OUT_I = 1'b0, SERIAL_CK_DIR_I = 1'b0;
   logic [3:0] c_ext = 4'hF, d_ext = 4'hF, pp_ext = 4'h0;
   logic [1:0] pd_ext = 2'h3;
   wire logic [3:0] RDATA_O, PORT_C_I, PORT_C_O, PORT_C_OE_O, PORT_D_I, PORT_D_O, PORT_D_OE_O;
   wire logic [3:0] PUSH_PULL_I, PUSH_PULL_O, PUSH_PULL_OE_O, PULLUP_ON_O;
   wire logic [1:0] PIN_D_I, PIN_D_O, PIN_D_OE_O;
   wire logic [7:0] ANALOG_CH_EN_O;
   wire logic TIMER2_CLK_O, TIMER4_CLK_O, EXT_IRQ_A_O, EXT_IRQ_B_O, WAKE_O, SERIAL_CK_IN_O, SERIAL_IN_O;
   wire logic COMPARATOR_EN_O;
   wire logic [3:0] sm_c_oe, sm_pp_oe;
   wire logic [7:0] sm_ach;
   int mismatches = 0;
   int checks = 0;
   port_pin_sharing_logic #(.SMALL_VARIANT(1'b0)) dut_u (.CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
      .RDATA_O, .PORT_C_I, .PORT_C_O, .PORT_C_OE_O, .PORT_D_I, .PORT_D_O, .PORT_D_OE_O, .PUSH_PULL_I,
      .PUSH_PULL_O, .PUSH_PULL_OE_O, .PIN_D_I, .PIN_D_O, .PIN_D_OE_O, .PORT_P2_I, .PORT_P0_I, .PORT_P1_I,
      .TIMER1_TOGGLE_I, .TIMER3_TOGGLE_I, .SERIAL_CK_OUT_I, .SERIAL_CK_DIR_I, .TIMER2_CLK_O, .TIMER4_CLK_O,
      .EXT_IRQ_A_O, .EXT_IRQ_B_O, .WAKE_O, .SERIAL_CK_IN_O, .SERIAL_IN_O, .ANALOG_CH_EN_O, .COMPARATOR_EN_O,
      .PULLUP_ON_O);
   board_model board_u (.c_oe_i(PORT_C_OE_O), .d_oe_i(PORT_D_OE_O), .pd_oe_i(PIN_D_OE_O), .pp_i(PUSH_PULL_O),
      .pp_oe_i(PUSH_PULL_OE_O), .c_ext_i(c_ext), .d_ext_i(d_ext), .pd_ext_i(pd_ext), .pp_ext_i(pp_ext),
      .c_o(PORT_C_I), .d_o(PORT_D_I), .pd_o(PIN_D_I), .pp_o(PUSH_PULL_I));
   // Smaller variant beside the full one, on the same bus and pins
   port_pin_sharing_logic #(.SMALL_VARIANT(1'b1)) small_u (.CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
      .RDATA_O(), .PORT_C_I, .PORT_C_O(), .PORT_C_OE_O(sm_c_oe), .PORT_D_I, .PORT_D_O(), .PORT_D_OE_O(),
      .PUSH_PULL_I, .PUSH_PULL_O(), .PUSH_PULL_OE_O(sm_pp_oe), .PIN_D_I, .PIN_D_O(), .PIN_D_OE_O(), .PORT_P2_I,
      .PORT_P0_I, .PORT_P1_I, .TIMER1_TOGGLE_I, .TIMER3_TOGGLE_I, .SERIAL_CK_OUT_I, .SERIAL_CK_DIR_I,
      .TIMER2_CLK_O(), .TIMER4_CLK_O(), .EXT_IRQ_A_O(), .EXT_IRQ_B_O(), .WAKE_O(), .SERIAL_CK_IN_O(),
      .SERIAL_IN_O(), .ANALOG_CH_EN_O(sm_ach), .COMPARATOR_EN_O(), .PULLUP_ON_O());
   initial forever #5 CLK_I = ~CLK_I;
   task automatic chk(input logic [8:0] s, input logic [8:0] e);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [3:0] e);
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1 chk(RDATA_O, e);
   endtask
   // Latch, enable register and two sync stages all lie in the path
   task automatic settle();
      repeat (6) @(posedge CLK_I);
      #1;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #200us;
      mismatches++;
      print_verdict();
   end
   initial
   begin
      repeat (16) @(posedge CLK_I);
      NRST_I <= 1'b1;
      settle();
      chk({PORT_C_OE_O, PORT_D_OE_O, PIN_D_OE_O}, 9'h0);
      chk(PUSH_PULL_OE_O, 4'h0);
      rd(ADDR_DIRECTION, DIR_RESET);
      rd(ADDR_PORT_C, 4'hF);
      @(posedge CLK_I);
      c_ext <= 4'h6;
      d_ext <= 4'h6;
      wr(ADDR_PORT_C, 4'hA);
      wr(ADDR_PORT_D, 4'hA);
      settle();
      chk({PORT_C_OE_O, PORT_D_OE_O}, 8'h55);
      rd(ADDR_PORT_C, 4'h2);
      rd(ADDR_PORT_D, 4'h2);
      @(posedge CLK_I);
      pp_ext <= 4'hA;
      wr(ADDR_PUSH_PULL, 4'hC);
      wr(ADDR_DIRECTION, 4'h5);
      settle();
      chk({PUSH_PULL_OE_O, PUSH_PULL_O & 4'h5}, 8'h54);
      chk({sm_c_oe, sm_pp_oe}, 8'h10);
      chk(sm_ach, 8'h0F);
      rd(ADDR_PUSH_PULL, 4'hE);
      @(posedge CLK_I);
      pd_ext <= 2'h2;
      settle();
      chk({TIMER4_CLK_O, TIMER2_CLK_O}, 2'h2);
      @(posedge CLK_I);
      pd_ext <= 2'h3;
      TIMER1_TOGGLE_I <= 1'b1;
      wr(ADDR_FUNC_SEL, 4'h3);
      settle();
      chk(PIN_D_OE_O, 2'h2);
      chk({TIMER4_CLK_O, TIMER2_CLK_O}, 2'h1);
      rd(ADDR_PIN_D, 4'h1);
      wr(ADDR_FUNC_SEL, FUNC_RESET);
      c_ext <= 4'hF;
      wr(ADDR_PORT_C, 4'hF);
      settle();
      chk(WAKE_O, 1'b0);
      @(posedge CLK_I);
      c_ext <= 4'hE;
      settle();
      chk({EXT_IRQ_B_O, EXT_IRQ_A_O, WAKE_O}, 3'h5);
      @(posedge CLK_I);
      c_ext <= 4'hF;
      PORT_P0_I <= 4'hE;
      wr(ADDR_KEYON, 4'h1);
      settle();
      chk(WAKE_O, 1'b1);
      wr(ADDR_KEYON, 4'h2);
      settle();
      chk(WAKE_O, 1'b0);
      @(posedge CLK_I);
      PORT_P1_I <= 4'hD;
      settle();
      chk(WAKE_O, 1'b1);
      rd(ADDR_PORT_P0, 4'hE);
      wr(ADDR_PULLUP, 4'h9);
      settle();
      chk(PULLUP_ON_O, 4'h9);
      @(posedge CLK_I);
      PORT_P2_I <= 3'h5;
      SERIAL_CK_DIR_I <= 1'b1;
      settle();
      chk({SERIAL_IN_O, SERIAL_CK_IN_O}, 2'h2);
      @(posedge CLK_I);
      SERIAL_CK_DIR_I <= 1'b0;
      settle();
      chk({SERIAL_IN_O, SERIAL_CK_IN_O}, 2'h3);
      rd(ADDR_PORT_P2, 4'h5);
      for (int i = 0; i < 2; i++)
      begin
         wr(ADDR_FUNC_SEL, i == 0 ? 4'h8 : 4'h0);
         settle();
         chk({COMPARATOR_EN_O, ANALOG_CH_EN_O}, i == 0 ? 9'h1F0 : 9'h0FF);
      end
      wr(4'hF, 4'h0);
      rd(4'hF, 4'h0);
      rd(ADDR_DIRECTION, 4'h5);
      @(posedge CLK_I);
      NRST_I <= 1'b0;
      @(posedge CLK_I);
      NRST_I <= 1'b1;
      settle();
      chk({PUSH_PULL_OE_O, PORT_C_OE_O}, 8'h00);
      rd(ADDR_DIRECTION, DIR_RESET);
      print_verdict();
   end
endmodule
`default_nettype wire
